// *** hdl/ucs_pkg.sv ***
// package of the serial channel command/status block
// assumes an 8-bit host register port with a 3-bit address
package ucs_pkg;
  // ****************************************
  // register addresses
  // ****************************************
  localparam logic [2:0] A_MODE = 3'h0;
  localparam logic [2:0] A_STATUS = 3'h1;
  localparam logic [2:0] A_CMD = 3'h2;
  localparam logic [2:0] A_DATA = 3'h3;
  localparam logic [2:0] A_AUX = 3'h4;
  localparam logic [2:0] A_IRQ = 3'h5;
  localparam logic [2:0] A_CTU = 3'h6;
  localparam logic [2:0] A_CTL = 3'h7;
  // ****************************************
  // command codes, upper nibble of command_reg
  // ****************************************
  localparam logic [3:0] CMD_NONE = 4'h0;
  localparam logic [3:0] CMD_MODE_PTR = 4'h1;
  localparam logic [3:0] CMD_RX_RST = 4'h2;
  localparam logic [3:0] CMD_TX_RST = 4'h3;
  localparam logic [3:0] CMD_ERR_RST = 4'h4;
  localparam logic [3:0] CMD_BRK_CHG_CLR = 4'h5;
  localparam logic [3:0] CMD_BRK_START = 4'h6;
  localparam logic [3:0] CMD_BRK_STOP = 4'h7;
  localparam logic [3:0] CMD_CT_START = 4'h8;
  localparam logic [3:0] CMD_CT_STOP = 4'h9;
  localparam logic [3:0] CMD_RTS_ON = 4'hA;
  localparam logic [3:0] CMD_RTS_OFF = 4'hB;
  localparam logic [3:0] CMD_MPI_CLR = 4'hC;
  // lower nibble bit positions
  localparam int CB_RX_EN = 0;
  localparam int CB_RX_DIS = 1;
  localparam int CB_TX_EN = 2;
  localparam int CB_TX_DIS = 3;
  // ****************************************
  // aux_control fields, reset values and used irq mask bits
  // ****************************************
  localparam int AUX_BAUD_SET = 7;
  localparam int AUX_CT_LSB = 4;
  localparam int AUX_PWR = 3;
  localparam int AUX_MPO_LSB = 0;
  localparam logic [7:0] AUX_RST = 8'h08;
  localparam logic [7:0] IMR_RST = 8'h00;
  localparam logic [15:0] PRESET_RST = 16'h0000;
  localparam logic [7:0] IMR_USED = 8'hDF;
  // ****************************************
  // counter/timer modes and prescale
  // ****************************************
  localparam logic [2:0] CT_C_MPI = 3'h0;
  localparam logic [2:0] CT_C_MPI16 = 3'h1;
  localparam logic [2:0] CT_C_TX1X = 3'h2;
  localparam logic [2:0] CT_C_XTAL16 = 3'h3;
  localparam logic [2:0] CT_T_MPI = 3'h4;
  localparam logic [2:0] CT_T_MPI16 = 3'h5;
  localparam logic [2:0] CT_T_XTAL = 3'h6;
  localparam logic [2:0] CT_T_XTAL16 = 3'h7;
  localparam int CT_MODE_TIMER = 2;
  localparam logic [3:0] PRE_LAST = 4'hF;
endpackage

// *** hdl/ucs_pin_sync.sv ***
// three-flop synchroniser for asynchronous pins
// assumes sys_clk_in much faster than the pin edges
`timescale 1ns/1ps
module ucs_pin_sync #(
  parameter int W = 1,
  parameter logic [W-1:0] RST_VAL = '0
) (
  input wire logic sys_clk_in,
  input wire logic sys_rst_in,
  input wire logic [W-1:0] pin_in,
  output logic [W-1:0] level_out
);
  logic [W-1:0] s1_ff, s2_ff, s3_ff, lvl_ff, nxt_lvl;
  // a change counts once stages two and three agree
  always_comb begin
    nxt_lvl = (~(s2_ff ^ s3_ff) & s3_ff) | ((s2_ff ^ s3_ff) & lvl_ff);
  end
  // synchroniser stages
  always_ff @(posedge sys_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      s1_ff <= RST_VAL;
      s2_ff <= RST_VAL;
      s3_ff <= RST_VAL;
      lvl_ff <= RST_VAL;
    end else begin
      s1_ff <= pin_in;
      s2_ff <= s1_ff;
      s3_ff <= s2_ff;
      lvl_ff <= nxt_lvl;
    end
  end
  assign level_out = lvl_ff;
endmodule

// *** hdl/ucs_rx_fifo.sv ***
// receive fifo holding each character with its error flags
// assumes push and pop come from logic on sys_clk_in
`timescale 1ns/1ps
module ucs_rx_fifo #(
  parameter int DW = 8,
  parameter int FW = 3,
  parameter int DEPTH = 3
) (
  input wire logic sys_clk_in,
  input wire logic sys_rst_in,
  input wire logic push_in,
  input wire logic [DW-1:0] data_in,
  input wire logic [FW-1:0] flags_in,
  input wire logic pop_in,
  input wire logic flush_in,
  input wire logic clr_flags_in,
  output logic [DW-1:0] head_data_out,
  output logic [FW-1:0] head_flags_out,
  output logic full_out,
  output logic empty_out
);
  localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam int CW = $clog2(DEPTH + 1);
  logic [FW+DW-1:0] mem_ff [DEPTH];
  logic [FW+DW-1:0] nxt_mem [DEPTH];
  logic [PW-1:0] rd_ff, nxt_rd, wr_idx;
  logic [CW-1:0] cnt_ff, nxt_cnt;
  logic [PW:0] wsum;
  logic do_push, do_pop;
  // pointer, count and storage update
  always_comb begin
    nxt_mem = mem_ff;
    nxt_rd = rd_ff;
    nxt_cnt = cnt_ff;
    wsum = {1'b0, rd_ff} + (PW+1)'(cnt_ff);
    wr_idx = (wsum >= (PW+1)'(DEPTH)) ? PW'(wsum - (PW+1)'(DEPTH)) : PW'(wsum);
    do_push = push_in && (cnt_ff != CW'(DEPTH));
    do_pop = pop_in && (cnt_ff != '0);
    // error reset wipes the stored flags of every entry
    if (clr_flags_in) begin
      for (int i = 0; i < DEPTH; i++) begin
        nxt_mem[i][FW+DW-1:DW] = '0;
      end
    end
    if (flush_in) begin
      nxt_rd = '0;
      nxt_cnt = '0;
    end else begin
      if (do_push) begin
        nxt_mem[wr_idx] = {flags_in, data_in};
      end
      if (do_pop) begin
        nxt_rd = (rd_ff == PW'(DEPTH - 1)) ? '0 : rd_ff + 1'b1;
      end
      nxt_cnt = cnt_ff + CW'(do_push) - CW'(do_pop);
    end
  end
  // fifo state registers
  always_ff @(posedge sys_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      for (int i = 0; i < DEPTH; i++) begin
        mem_ff[i] <= '0;
      end
      rd_ff <= '0;
      cnt_ff <= '0;
    end else begin
      mem_ff <= nxt_mem;
      rd_ff <= nxt_rd;
      cnt_ff <= nxt_cnt;
    end
  end
  assign head_data_out = mem_ff[rd_ff][DW-1:0];
  assign head_flags_out = empty_out ? '0 : mem_ff[rd_ff][FW+DW-1:DW];
  assign full_out = (cnt_ff == CW'(DEPTH));
  assign empty_out = (cnt_ff == '0);
endmodule

// *** hdl/ucs_regs.sv ***
// command, status, aux control, irq and counter preset registers
// assumes the host holds address and data stable across each strobe
// and that receiver, transmitter and baud clocks run on sys_clk_in
//
// Behaviour
// - command codes 1-4: pointer, rx, tx, errors
// - codes 5-7: break change clear, break
// - codes 8-C: counter, request to send, input
// - low nibble enables and disables rx, tx
// - status bits report the channel condition
// - error flags travel with each fifo character
// - error reset command clears stored flags
// - character mode flags leave with character
// - aux bit 7 picks baud table
// - aux bit 3 low means power down
// - aux bits 2:0 pick output pin source
// - aux bits 6:4 pick counter mode, source
// - irq status bits report interrupt sources
// - mask bits enable matching status bits
// - sixteen bit preset in two bytes
// - single active low interrupt request output
`timescale 1ns/1ps
module ucs_regs #(
  parameter int FIFO_DEPTH = 3
) (
  input wire logic sys_clk_in,
  input wire logic sys_rst_in,
  input wire logic bus_cs_n_in,
  input wire logic bus_wr_n_in,
  input wire logic bus_rd_n_in,
  input wire logic [2:0] bus_addr_in,
  input wire logic [7:0] bus_data_in,
  output logic [7:0] bus_data_out,
  output logic bus_data_oe_out,
  output logic interrupt_request_n_out,
  input wire logic rx_push_in,
  input wire logic [7:0] rx_char_in,
  input wire logic [2:0] rx_err_flags_in,
  input wire logic rx_block_err_mode_in,
  input wire logic rx_int_on_full_in,
  input wire logic break_change_in,
  input wire logic transmitter_empty_in,
  input wire logic transmit_holding_ready_in,
  input wire logic transmit_clock_1x_in,
  input wire logic transmit_clock_16x_in,
  input wire logic receive_clock_1x_in,
  input wire logic receive_clock_16x_in,
  input wire logic multi_purpose_input_in,
  output logic multi_purpose_output_out,
  output logic request_to_send_n_out,
  output logic counter_timer_output_out,
  output logic rx_enable_out,
  output logic tx_enable_out,
  output logic mode_ptr_reset_out,
  output logic rx_reset_out,
  output logic tx_reset_out,
  output logic break_send_out,
  output logic power_down_out,
  output logic baud_set_out
);
  // ****************************************
  // pin synchronisers and strobe edges
  // ****************************************
  logic [3:0] pins_lvl;
  logic cs_n_s, wr_n_s, rd_n_s, mpi_s;
  logic wr_act_ff, rd_act_ff, mpi_d_ff;
  logic wr_act, rd_act, wr_pulse, rd_pulse, mpi_rise, mpi_edge;
  ucs_pin_sync #(
    .W(4),
    .RST_VAL(4'h7)
  ) u_sync (
    .sys_clk_in(sys_clk_in),
    .sys_rst_in(sys_rst_in),
    .pin_in({multi_purpose_input_in, bus_rd_n_in, bus_wr_n_in, bus_cs_n_in}),
    .level_out(pins_lvl)
  );
  assign {mpi_s, rd_n_s, wr_n_s, cs_n_s} = pins_lvl;
  // strobe start detection
  assign wr_act = ~cs_n_s & ~wr_n_s;
  assign rd_act = ~cs_n_s & ~rd_n_s;
  assign wr_pulse = wr_act & ~wr_act_ff;
  assign rd_pulse = rd_act & ~rd_act_ff;
  assign mpi_rise = mpi_s & ~mpi_d_ff;
  assign mpi_edge = mpi_s ^ mpi_d_ff;
  // ****************************************
  // receive fifo
  // ****************************************
  logic [7:0] head_data;
  logic [2:0] head_flags;
  logic fifo_full, fifo_empty, pop, err_rst, rx_rst_cmd, rx_en_ff;
  logic [3:0] cmd;
  logic cmd_wr;
  assign cmd_wr = wr_pulse && (bus_addr_in == ucs_pkg::A_CMD);
  assign cmd = cmd_wr ? bus_data_in[7:4] : ucs_pkg::CMD_NONE;
  assign err_rst = (cmd == ucs_pkg::CMD_ERR_RST);
  assign rx_rst_cmd = (cmd == ucs_pkg::CMD_RX_RST);
  // a data read pops the head in the same edge it is latched
  assign pop = rd_pulse && (bus_addr_in == ucs_pkg::A_DATA);
  ucs_rx_fifo #(
    .DW(8),
    .FW(3),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .sys_clk_in(sys_clk_in),
    .sys_rst_in(sys_rst_in),
    .push_in(rx_push_in & rx_en_ff),
    .data_in(rx_char_in),
    .flags_in(rx_err_flags_in),
    .pop_in(pop),
    .flush_in(rx_rst_cmd),
    .clr_flags_in(err_rst),
    .head_data_out(head_data),
    .head_flags_out(head_flags),
    .full_out(fifo_full),
    .empty_out(fifo_empty)
  );
  // ****************************************
  // control registers
  // ****************************************
  logic [7:0] aux_ff, nxt_aux, imr_ff, nxt_imr;
  logic [15:0] preset_ff, nxt_preset;
  logic nxt_rx_en, tx_en_ff, nxt_tx_en;
  logic rts_ff, nxt_rts, brk_ff, nxt_brk;
  logic mpi_chg_ff, nxt_mpi_chg, brk_chg_ff, nxt_brk_chg;
  logic ovr_ff, nxt_ovr;
  logic [2:0] blk_err_ff, nxt_blk_err;
  logic [2:0] pulse_ff, nxt_pulse;
  // register writes and command decode
  always_comb begin
    nxt_aux = aux_ff;
    nxt_imr = imr_ff;
    nxt_preset = preset_ff;
    nxt_rx_en = rx_en_ff;
    nxt_tx_en = tx_en_ff;
    nxt_rts = rts_ff;
    nxt_brk = brk_ff;
    nxt_mpi_chg = mpi_chg_ff;
    nxt_brk_chg = brk_chg_ff;
    nxt_ovr = ovr_ff;
    nxt_blk_err = blk_err_ff;
    nxt_pulse = 3'h0;
    if (wr_pulse) begin
      case (bus_addr_in)
        ucs_pkg::A_AUX: nxt_aux = bus_data_in;
        ucs_pkg::A_IRQ: nxt_imr = bus_data_in;
        // preset bytes map bit for bit
        ucs_pkg::A_CTU: nxt_preset[15:8] = bus_data_in;
        ucs_pkg::A_CTL: nxt_preset[7:0] = bus_data_in;
        default: nxt_preset = preset_ff;
      endcase
    end
    if (cmd_wr) begin
      if (bus_data_in[ucs_pkg::CB_RX_EN]) nxt_rx_en = 1'b1;
      if (bus_data_in[ucs_pkg::CB_RX_DIS]) nxt_rx_en = 1'b0;
      if (bus_data_in[ucs_pkg::CB_TX_EN]) nxt_tx_en = 1'b1;
      if (bus_data_in[ucs_pkg::CB_TX_DIS]) nxt_tx_en = 1'b0;
    end
    case (cmd)
      ucs_pkg::CMD_MODE_PTR: nxt_pulse[0] = 1'b1;
      ucs_pkg::CMD_RX_RST: begin
        nxt_pulse[1] = 1'b1;
        nxt_rx_en = 1'b0;
      end
      ucs_pkg::CMD_TX_RST: begin
        nxt_pulse[2] = 1'b1;
        nxt_tx_en = 1'b0;
      end
      ucs_pkg::CMD_ERR_RST: begin
        nxt_ovr = 1'b0;
        nxt_blk_err = 3'h0;
      end
      ucs_pkg::CMD_BRK_CHG_CLR: nxt_brk_chg = 1'b0;
      ucs_pkg::CMD_BRK_START: nxt_brk = 1'b1;
      ucs_pkg::CMD_BRK_STOP: nxt_brk = 1'b0;
      ucs_pkg::CMD_RTS_ON: nxt_rts = 1'b1;
      ucs_pkg::CMD_RTS_OFF: nxt_rts = 1'b0;
      ucs_pkg::CMD_MPI_CLR: nxt_mpi_chg = 1'b0;
      default: nxt_rts = nxt_rts;
    endcase
    // events set after the clears so a set in the clear cycle wins
    if (break_change_in) nxt_brk_chg = 1'b1;
    if (mpi_edge) nxt_mpi_chg = 1'b1;
    if (rx_push_in && rx_en_ff) begin
      if (fifo_full) nxt_ovr = 1'b1;
      else nxt_blk_err = nxt_blk_err | rx_err_flags_in;
    end
  end
  // control state registers
  always_ff @(posedge sys_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      aux_ff <= ucs_pkg::AUX_RST;
      imr_ff <= ucs_pkg::IMR_RST;
      preset_ff <= ucs_pkg::PRESET_RST;
      rx_en_ff <= 1'b0;
      tx_en_ff <= 1'b0;
      rts_ff <= 1'b0;
      brk_ff <= 1'b0;
      mpi_chg_ff <= 1'b0;
      brk_chg_ff <= 1'b0;
      ovr_ff <= 1'b0;
      blk_err_ff <= 3'h0;
      pulse_ff <= 3'h0;
      wr_act_ff <= 1'b0;
      rd_act_ff <= 1'b0;
      mpi_d_ff <= 1'b0;
    end else begin
      aux_ff <= nxt_aux;
      imr_ff <= nxt_imr;
      preset_ff <= nxt_preset;
      rx_en_ff <= nxt_rx_en;
      tx_en_ff <= nxt_tx_en;
      rts_ff <= nxt_rts;
      brk_ff <= nxt_brk;
      mpi_chg_ff <= nxt_mpi_chg;
      brk_chg_ff <= nxt_brk_chg;
      ovr_ff <= nxt_ovr;
      blk_err_ff <= nxt_blk_err;
      pulse_ff <= nxt_pulse;
      wr_act_ff <= wr_act;
      rd_act_ff <= rd_act;
      mpi_d_ff <= mpi_s;
    end
  end
  // ****************************************
  // counter/timer
  // ****************************************
  logic [15:0] ct_ff, nxt_ct;
  logic ct_run_ff, nxt_ct_run, ct_rdy_ff, nxt_ct_rdy, ct_out_ff, nxt_ct_out;
  logic [3:0] pre_ff, nxt_pre, mpre_ff, nxt_mpre;
  logic tick, ct_timer;
  logic [2:0] ct_mode;
  assign ct_mode = aux_ff[ucs_pkg::AUX_CT_LSB +: 3];
  assign ct_timer = ct_mode[ucs_pkg::CT_MODE_TIMER];
  // source selection and count down
  always_comb begin
    nxt_pre = pre_ff + 4'h1;
    nxt_mpre = mpre_ff + 4'(mpi_rise);
    nxt_ct = ct_ff;
    nxt_ct_run = ct_run_ff;
    nxt_ct_rdy = ct_rdy_ff;
    nxt_ct_out = ct_out_ff;
    case (ct_mode)
      ucs_pkg::CT_C_MPI, ucs_pkg::CT_T_MPI: tick = mpi_rise;
      ucs_pkg::CT_C_MPI16, ucs_pkg::CT_T_MPI16: tick = mpi_rise && (mpre_ff == ucs_pkg::PRE_LAST);
      ucs_pkg::CT_C_TX1X: tick = transmit_clock_1x_in;
      ucs_pkg::CT_T_XTAL: tick = 1'b1;
      default: tick = (pre_ff == ucs_pkg::PRE_LAST);
    endcase
    if (cmd == ucs_pkg::CMD_CT_START) begin
      nxt_ct = preset_ff;
      nxt_ct_run = 1'b1;
      nxt_ct_rdy = 1'b0;
    end else if (cmd == ucs_pkg::CMD_CT_STOP) begin
      nxt_ct_run = 1'b0;
      nxt_ct_rdy = 1'b0;
    end else if (ct_run_ff && tick) begin
      if (ct_ff <= 16'h0001) begin
        nxt_ct_rdy = 1'b1;
        nxt_ct_out = ~ct_out_ff;
        nxt_ct = ct_timer ? preset_ff : 16'h0000;
        nxt_ct_run = ct_timer;
      end else begin
        nxt_ct = ct_ff - 16'h0001;
      end
    end
  end
  // counter/timer registers
  always_ff @(posedge sys_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      ct_ff <= 16'h0000;
      ct_run_ff <= 1'b0;
      ct_rdy_ff <= 1'b0;
      ct_out_ff <= 1'b0;
      pre_ff <= 4'h0;
      mpre_ff <= 4'h0;
    end else begin
      ct_ff <= nxt_ct;
      ct_run_ff <= nxt_ct_run;
      ct_rdy_ff <= nxt_ct_rdy;
      ct_out_ff <= nxt_ct_out;
      pre_ff <= nxt_pre;
      mpre_ff <= nxt_mpre;
    end
  end
  // ****************************************
  // status, read data and outputs
  // ****************************************
  logic [7:0] status, irq_status, rd_mux, rd_data_ff;
  logic rx_int, mpo_ff, nxt_mpo, irq_n_ff;
  assign rx_int = rx_int_on_full_in ? fifo_full : ~fifo_empty;
  // head flags or accumulated block flags
  assign status = {(rx_block_err_mode_in ? blk_err_ff : head_flags), ovr_ff, transmitter_empty_in,
                   transmit_holding_ready_in, fifo_full, ~fifo_empty};
  assign irq_status = {mpi_chg_ff, mpi_s, 1'b0, ct_rdy_ff, brk_chg_ff, rx_int, transmitter_empty_in,
                transmit_holding_ready_in};
  // read multiplexer, write-only places read zero
  always_comb begin
    case (bus_addr_in)
      ucs_pkg::A_STATUS: rd_mux = status;
      ucs_pkg::A_DATA: rd_mux = head_data;
      ucs_pkg::A_IRQ: rd_mux = irq_status;
      ucs_pkg::A_CTU: rd_mux = ct_ff[15:8];
      ucs_pkg::A_CTL: rd_mux = ct_ff[7:0];
      default: rd_mux = 8'h00;
    endcase
    case (aux_ff[ucs_pkg::AUX_MPO_LSB +: 3])
      3'h0: nxt_mpo = ~rts_ff;
      3'h1: nxt_mpo = ct_out_ff;
      3'h2: nxt_mpo = transmit_clock_1x_in;
      3'h3: nxt_mpo = transmit_clock_16x_in;
      3'h4: nxt_mpo = receive_clock_1x_in;
      3'h5: nxt_mpo = receive_clock_16x_in;
      3'h6: nxt_mpo = transmit_holding_ready_in;
      default: nxt_mpo = rx_int;
    endcase
  end
  // output registers
  always_ff @(posedge sys_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      rd_data_ff <= 8'h00;
      mpo_ff <= 1'b1;
      irq_n_ff <= 1'b1;
    end else begin
      rd_data_ff <= rd_pulse ? rd_mux : rd_data_ff;
      mpo_ff <= nxt_mpo;
      irq_n_ff <= ~|(irq_status & imr_ff & ucs_pkg::IMR_USED);
    end
  end
  assign bus_data_out = rd_data_ff;
  assign bus_data_oe_out = rd_act;
  assign interrupt_request_n_out = irq_n_ff;
  assign multi_purpose_output_out = mpo_ff;
  assign request_to_send_n_out = ~rts_ff;
  assign counter_timer_output_out = ct_out_ff;
  assign rx_enable_out = rx_en_ff;
  assign tx_enable_out = tx_en_ff;
  assign {tx_reset_out, rx_reset_out, mode_ptr_reset_out} = pulse_ff;
  assign break_send_out = brk_ff;
  assign power_down_out = ~aux_ff[ucs_pkg::AUX_PWR];
  assign baud_set_out = aux_ff[ucs_pkg::AUX_BAUD_SET];
  // ****************************************
  // assertions
  // ****************************************
  break_start_a: assert property (@(posedge sys_clk_in) disable iff (sys_rst_in)
    (cmd == ucs_pkg::CMD_BRK_START) |=> break_send_out) else $error("break not started");
  rts_drive_a: assert property (@(posedge sys_clk_in) disable iff (sys_rst_in)
    (cmd == ucs_pkg::CMD_RTS_OFF) |=> request_to_send_n_out) else $error("rts not released");
  rx_enable_a: assert property (@(posedge sys_clk_in) disable iff (sys_rst_in)
    (cmd_wr && bus_data_in[1]) |=> !rx_enable_out) else $error("receiver not disabled");
  rx_reset_a: assert property (@(posedge sys_clk_in) disable iff (sys_rst_in)
    rx_rst_cmd |=> rx_reset_out ##1 (!rx_reset_out && fifo_empty)) else $error("rx reset wrong");
  err_clear_a: assert property (@(posedge sys_clk_in) disable iff (sys_rst_in)
    (err_rst && !rx_push_in) |=> (status[7:4] == 4'h0))
    else $error("error flags not cleared");
  brk_chg_win_a: assert property (@(posedge sys_clk_in) disable iff (sys_rst_in)
    (cmd == ucs_pkg::CMD_BRK_CHG_CLR && break_change_in) |=> irq_status[3]) else $error("break change lost");
  irq_out_a: assert property (@(posedge sys_clk_in) disable iff (sys_rst_in)
    $past(|(irq_status & imr_ff & ucs_pkg::IMR_USED)) == !interrupt_request_n_out) else $error("irq mismatch");
  power_down_a: assert property (@(posedge sys_clk_in) disable iff (sys_rst_in)
    (wr_pulse && bus_addr_in == 3'h4 && !bus_data_in[3]) |=> power_down_out) else $error("power down missed");
  preset_low_a: assert property (@(posedge sys_clk_in) disable iff (sys_rst_in)
    (wr_pulse && bus_addr_in == 3'h7) |=> preset_ff[7:0] == $past(bus_data_in)) else $error("preset low wrong");
  ct_start_a: assert property (@(posedge sys_clk_in) disable iff (sys_rst_in)
    (cmd == ucs_pkg::CMD_CT_START) |=> (ct_run_ff && !ct_rdy_ff && ct_ff == $past(preset_ff)))
    else $error("counter start wrong");
endmodule

// *** tb/ucs_host_model.sv ***
// host processor model driving the register port pins
// assumes the bench calls its tasks from one process only
`timescale 1ns/1ps
module ucs_host_model (
  input wire logic sys_clk_in,
  input wire logic [7:0] rd_data_in,
  output logic cs_n_out,
  output logic wr_n_out,
  output logic rd_n_out,
  output logic [2:0] addr_out,
  output logic [7:0] wr_data_out
);
  // idle pins; data shows a changing pattern while released
  initial begin
    cs_n_out = 1'b1;
    wr_n_out = 1'b1;
    rd_n_out = 1'b1;
    addr_out = 3'h0;
    wr_data_out = 8'hA5;
  end
  // strobes low 7 cycles and high 7 cycles, changes on falling edges
  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    @(negedge sys_clk_in);
    addr_out = a;
    wr_data_out = d;
    cs_n_out = 1'b0;
    wr_n_out = 1'b0;
    repeat (7) @(negedge sys_clk_in);
    cs_n_out = 1'b1;
    wr_n_out = 1'b1;
    wr_data_out = ~d;
    repeat (7) @(negedge sys_clk_in);
  endtask
  task automatic rd(input logic [2:0] a, output logic [7:0] d);
    @(negedge sys_clk_in);
    addr_out = a;
    cs_n_out = 1'b0;
    rd_n_out = 1'b0;
    repeat (7) @(negedge sys_clk_in);
    d = rd_data_in;
    cs_n_out = 1'b1;
    rd_n_out = 1'b1;
    repeat (7) @(negedge sys_clk_in);
  endtask
  task automatic wr_preset(input logic [15:0] v);
    wr(ucs_pkg::A_CTU, v[15:8]);
    wr(ucs_pkg::A_CTL, v[7:0]);
  endtask
endmodule

// *** tb/ucs_regs_tb.sv ***
// self-checking bench of the register block
// assumes the host model holds every bus timing
`timescale 1ns/1ps
module ucs_regs_tb;
  logic sys_clk_in, sys_rst_in, cs_n, wr_n, rd_n, oe, irq_n, push, thr_rdy, tx_emt, multi_purpose_output, rts_n;
  logic ct_o, multi_purpose_input, brk_chg, oe_seen, bmode;
  logic rx_en, tx_en, mp_rst, rx_rst, tx_rst, brk, pd, baud;
  logic [2:0] addr, flags, seen;
  logic [7:0] wdata, rdata, rch, r;
  logic [3:0] div;
  int miscompares, total_checks, cyc;
  ucs_host_model i_ucs_host_model (.sys_clk_in(sys_clk_in), .rd_data_in(rdata), .cs_n_out(cs_n),
    .wr_n_out(wr_n), .rd_n_out(rd_n), .addr_out(addr), .wr_data_out(wdata));
  ucs_regs i_ucs_regs (.sys_clk_in(sys_clk_in), .sys_rst_in(sys_rst_in), .bus_cs_n_in(cs_n),
    .bus_wr_n_in(wr_n), .bus_rd_n_in(rd_n), .bus_addr_in(addr), .bus_data_in(wdata),
    .bus_data_out(rdata), .bus_data_oe_out(oe), .interrupt_request_n_out(irq_n), .rx_push_in(push),
    .rx_char_in(rch), .rx_err_flags_in(flags), .rx_block_err_mode_in(bmode), .rx_int_on_full_in(1'b0),
    .break_change_in(brk_chg), .transmitter_empty_in(tx_emt), .transmit_holding_ready_in(thr_rdy),
    .transmit_clock_1x_in(div[0]), .transmit_clock_16x_in(div[1]), .receive_clock_1x_in(div[2]),
    .receive_clock_16x_in(div[3]), .multi_purpose_input_in(multi_purpose_input), .multi_purpose_output_out(multi_purpose_output),
    .request_to_send_n_out(rts_n), .counter_timer_output_out(ct_o), .rx_enable_out(rx_en),
    .tx_enable_out(tx_en), .mode_ptr_reset_out(mp_rst), .rx_reset_out(rx_rst), .tx_reset_out(tx_rst),
    .break_send_out(brk), .power_down_out(pd), .baud_set_out(baud));
  // clock, divided line clocks, pulse capture and hang guard
  initial begin
    sys_clk_in = 1'b0;
    forever #25 sys_clk_in = ~sys_clk_in;
  end
  always @(negedge sys_clk_in) div <= div + 4'h1;
  always @(posedge sys_clk_in) begin
    seen <= seen | {tx_rst, rx_rst, mp_rst};
    oe_seen <= oe_seen | oe;
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      miscompares++;
      report_and_stop();
    end
  end
  task automatic chk(input string n, input logic [7:0] got, input logic [7:0] exp);
    total_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("wrong value %s expected %h seen %h", n, exp, got);
    end
  endtask
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic push_char(input logic [7:0] c, input logic [2:0] f);
    @(negedge sys_clk_in);
    push = 1'b1;
    rch = c;
    flags = f;
    @(negedge sys_clk_in);
    push = 1'b0;
    rch = ~c;
  endtask
  // ****************************************
  // scenarios
  // ****************************************
  task automatic t_cmds();
    chk("irq_n", irq_n, 1);
    chk("rts_n", rts_n, 1);
    chk("pd", pd, 0);
    chk("mpo", multi_purpose_output, 1);
    i_ucs_host_model.wr(ucs_pkg::A_CMD, 8'h05);
    chk("rx_en", rx_en, 1); chk("tx_en", tx_en, 1);
    i_ucs_host_model.wr(ucs_pkg::A_CMD, 8'h0A);
    chk("en", {rx_en, tx_en}, 0);
    for (int c = 1; c <= 3; c++) begin
      seen = 3'b000;
      i_ucs_host_model.wr(ucs_pkg::A_CMD, {c[3:0], 4'h0});
      chk("pulse", seen, 8'h01 << (c - 1));
    end
    i_ucs_host_model.wr(ucs_pkg::A_CMD, 8'h60);
    chk("brk on", brk, 1);
    i_ucs_host_model.wr(ucs_pkg::A_CMD, 8'h70);
    chk("brk off", brk, 0);
    i_ucs_host_model.wr(ucs_pkg::A_CMD, 8'hA0);
    chk("rts on", rts_n, 0);
    chk("mpo rts", multi_purpose_output, 0);
    i_ucs_host_model.wr(ucs_pkg::A_CMD, 8'hB0);
    chk("rts off", rts_n, 1);
    $display("test commands done");
  endtask
  task automatic t_aux();
    i_ucs_host_model.wr(ucs_pkg::A_AUX, 8'h80);
    chk("baud", baud, 1);
    chk("pd on", pd, 1);
    i_ucs_host_model.wr(ucs_pkg::A_AUX, 8'h0E);
    chk("pd off", pd, 0);
    chk("mpo transmit_holding_ready", multi_purpose_output, 0);
    thr_rdy = 1'b1;
    repeat (3) @(negedge sys_clk_in);
    chk("mpo transmit_holding_ready", multi_purpose_output, 1);
    thr_rdy = 1'b0;
    i_ucs_host_model.wr(ucs_pkg::A_AUX, 8'h08);
    i_ucs_host_model.wr_preset(16'h1234);
    $display("test aux done");
  endtask
  task automatic t_fifo();
    i_ucs_host_model.wr(ucs_pkg::A_CMD, 8'h01);
    push_char(8'h5A, 3'b101);
    oe_seen = 1'b0;
    i_ucs_host_model.rd(ucs_pkg::A_STATUS, r);
    chk("status", r, 8'hA1);
    chk("oe", {oe_seen, oe}, 8'h02);
    i_ucs_host_model.rd(ucs_pkg::A_DATA, r);
    chk("char", r, 8'h5A);
    i_ucs_host_model.rd(ucs_pkg::A_STATUS, r);
    chk("status", r, 8'h00);
    push_char(8'h33, 3'b111);
    i_ucs_host_model.wr(ucs_pkg::A_CMD, 8'h40);
    i_ucs_host_model.rd(ucs_pkg::A_STATUS, r);
    chk("status", r, 8'h01);
    i_ucs_host_model.rd(ucs_pkg::A_DATA, r);
    $display("test fifo done");
  endtask
  task automatic t_irq();
    thr_rdy = 1'b1;
    tx_emt = 1'b1;
    i_ucs_host_model.wr(ucs_pkg::A_IRQ, 8'h01);
    chk("irq_n", irq_n, 0);
    i_ucs_host_model.rd(ucs_pkg::A_IRQ, r);
    chk("isr", r, 8'h03);
    thr_rdy = 1'b0;
    repeat (3) @(negedge sys_clk_in);
    chk("irq_n", irq_n, 1);
    i_ucs_host_model.wr(ucs_pkg::A_IRQ, 8'h02);
    chk("irq_n", irq_n, 0);
    i_ucs_host_model.wr(ucs_pkg::A_IRQ, 8'h00);
    chk("irq_n", irq_n, 1);
    $display("test irq done");
  endtask
  // counter value, counter terminal count, ready flag and output
  task automatic t_ct();
    i_ucs_host_model.wr(ucs_pkg::A_CMD, 8'h80);
    i_ucs_host_model.rd(ucs_pkg::A_CTU, r);
    chk("ct hi", r, 8'h12);
    i_ucs_host_model.rd(ucs_pkg::A_CTL, r);
    chk("ct lo", r, 8'h34);
    i_ucs_host_model.wr_preset(16'h0002);
    i_ucs_host_model.wr(ucs_pkg::A_AUX, 8'h39);
    i_ucs_host_model.wr(ucs_pkg::A_CMD, 8'h80);
    repeat (40) @(negedge sys_clk_in);
    i_ucs_host_model.rd(ucs_pkg::A_IRQ, r);
    chk("ct rdy", r, 8'h10);
    chk("ct out", {multi_purpose_output, ct_o}, 8'h03);
    i_ucs_host_model.wr(ucs_pkg::A_CMD, 8'h90);
    i_ucs_host_model.rd(ucs_pkg::A_IRQ, r);
    chk("ct stop", r, 8'h00);
    i_ucs_host_model.wr(ucs_pkg::A_AUX, 8'h08);
    $display("test counter done");
  endtask
  // input pin and break change flags, block error mode
  task automatic t_events();
    multi_purpose_input = 1'b1;
    brk_chg = 1'b1;
    @(negedge sys_clk_in);
    brk_chg = 1'b0;
    repeat (6) @(negedge sys_clk_in);
    i_ucs_host_model.rd(ucs_pkg::A_IRQ, r);
    chk("isr events", r, 8'hCA);
    i_ucs_host_model.wr(ucs_pkg::A_CMD, 8'hC0);
    i_ucs_host_model.wr(ucs_pkg::A_CMD, 8'h50);
    i_ucs_host_model.rd(ucs_pkg::A_IRQ, r);
    chk("isr cleared", r, 8'h42);
    bmode = 1'b1;
    push_char(8'h11, 3'b010);
    push_char(8'h22, 3'b001);
    i_ucs_host_model.rd(ucs_pkg::A_STATUS, r);
    chk("block flags", r, 8'h69);
    $display("test events done");
  endtask
  // reset for 3 cycles, then run each scenario
  initial begin
    sys_rst_in = 1'b1;
    push = 1'b0;
    rch = 8'h00;
    flags = 3'b000;
    thr_rdy = 1'b0;
    tx_emt = 1'b0;
    div = 4'h0;
    seen = 3'b000;
    cyc = 0;
    multi_purpose_input = 1'b0;
    brk_chg = 1'b0;
    oe_seen = 1'b0;
    bmode = 1'b0;
    repeat (3) @(negedge sys_clk_in);
    sys_rst_in = 1'b0;
    t_cmds();
    t_aux();
    t_ct();
    t_fifo();
    t_irq();
    t_events();
    report_and_stop();
  end
endmodule
